// ==== thermal_sensor_regs.sv ====
// Two-wire slave port and register set of the digital thermal sensor
`timescale 1ns/1ps
module thermal_sensor_regs (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [6:0] dev_addr,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire thermal_pkg::sample_type sample,
    output logic low_power_select,
    output logic data_ready
);

    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    logic [1:0] rst_pipe_ff;
    logic rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_ff[1];

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // The bus clock is only sampled; its edges are found here
    thermal_pkg::lines_type meta_ff;
    thermal_pkg::lines_type sync_ff;
    thermal_pkg::lines_type prev_ff;
    logic [6:0] addr_meta_ff;
    logic [6:0] addr_sync_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 2'b11;
            sync_ff <= 2'b11;
            prev_ff <= 2'b11;
        end else begin
            meta_ff <= {scl_pin, sda_in};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Address straps are static but still cross in from the pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_meta_ff <= thermal_pkg::ADDR_DEFAULT;
            addr_sync_ff <= thermal_pkg::ADDR_DEFAULT;
        end else begin
            addr_meta_ff <= dev_addr;
            addr_sync_ff <= addr_meta_ff;
        end
    end

    // --------------------------------------------------------------
    // Bus events
    // --------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_rise = sync_ff.scl && !prev_ff.scl;
    assign scl_fall = !sync_ff.scl && prev_ff.scl;
    assign start_seen = sync_ff.scl && prev_ff.scl && prev_ff.sda && !sync_ff.sda;
    assign stop_seen = sync_ff.scl && prev_ff.scl && !prev_ff.sda && sync_ff.sda;

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic [7:0] pointer_ff;
    logic [7:0] reading;
    logic ready;
    logic [7:0] setup_view;

    // Only the switch is stored; the flag and reserved bits are built here
    always_comb begin
        setup_view = thermal_pkg::SETUP_RESET;
        setup_view[thermal_pkg::LOW_POWER_BIT] = low_power_select;
        setup_view[thermal_pkg::READY_BIT] = ready;
    end

    function automatic logic [7:0] read_mux(
        input logic [7:0] ptr,
        input logic [7:0] temp_val,
        input logic [7:0] setup_val
    );
        logic [7:0] result;
        result = 8'h00;
        if (ptr == thermal_pkg::REG_THERMAL_READING) begin
            result = temp_val;
        end else if (ptr == thermal_pkg::REG_SETUP_AND_FLAGS) begin
            result = setup_val;
        end
        return result;
    endfunction

    // --------------------------------------------------------------
    // Link state machine
    // --------------------------------------------------------------
    thermal_pkg::link_state_type state_ff;
    thermal_pkg::link_state_type after_ack_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_shift_ff;
    logic [7:0] tx_shift_ff;
    logic host_nack_ff;
    logic sda_oe_ff;
    logic rx_state;
    logic rx_done;
    logic addr_match;
    logic cmd_take;
    logic wr_take;
    logic [7:0] read_value;

    assign rx_state = (state_ff == thermal_pkg::st_addr) ||
                      (state_ff == thermal_pkg::st_cmd) ||
                      (state_ff == thermal_pkg::st_wdata);
    assign rx_done = scl_fall && rx_state && (bit_cnt_ff == thermal_pkg::BYTE_BITS);
    assign addr_match = (rx_shift_ff[7:1] == addr_sync_ff);
    assign cmd_take = rx_done && (state_ff == thermal_pkg::st_cmd);
    assign wr_take = rx_done && (state_ff == thermal_pkg::st_wdata);
    assign read_value = read_mux(pointer_ff, reading, setup_view);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= thermal_pkg::st_idle;
            after_ack_ff <= thermal_pkg::st_idle;
            bit_cnt_ff <= thermal_pkg::BIT_ZERO;
            rx_shift_ff <= 8'h00;
            tx_shift_ff <= 8'h00;
            host_nack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (start_seen) begin
            // Repeated start is taken in any state
            state_ff <= thermal_pkg::st_addr;
            bit_cnt_ff <= thermal_pkg::BIT_ZERO;
            sda_oe_ff <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= thermal_pkg::st_idle;
            sda_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                thermal_pkg::st_addr, thermal_pkg::st_cmd, thermal_pkg::st_wdata: begin
                    if (scl_rise) begin
                        rx_shift_ff <= {rx_shift_ff[6:0], sync_ff.sda};
                        bit_cnt_ff <= bit_cnt_ff + thermal_pkg::BIT_STEP;
                    end else if (rx_done) begin
                        if (state_ff == thermal_pkg::st_addr && !addr_match) begin
                            state_ff <= thermal_pkg::st_idle;
                        end else begin
                            sda_oe_ff <= 1'b1;
                            state_ff <= thermal_pkg::st_ack;
                            if (state_ff != thermal_pkg::st_addr) begin
                                after_ack_ff <= thermal_pkg::st_wdata;
                            end else if (rx_shift_ff[thermal_pkg::DIR_BIT]) begin
                                after_ack_ff <= thermal_pkg::st_rdata;
                            end else begin
                                after_ack_ff <= thermal_pkg::st_cmd;
                            end
                        end
                    end
                end
                thermal_pkg::st_ack: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= thermal_pkg::BIT_ZERO;
                        state_ff <= after_ack_ff;
                        if (after_ack_ff == thermal_pkg::st_rdata) begin
                            tx_shift_ff <= read_value;
                            sda_oe_ff <= !read_value[7];
                        end else begin
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                thermal_pkg::st_rdata: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + thermal_pkg::BIT_STEP;
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == thermal_pkg::BYTE_BITS) begin
                            sda_oe_ff <= 1'b0;
                            state_ff <= thermal_pkg::st_mack;
                        end else begin
                            tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
                            sda_oe_ff <= !tx_shift_ff[6];
                        end
                    end
                end
                thermal_pkg::st_mack: begin
                    if (scl_rise) begin
                        host_nack_ff <= sync_ff.sda;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= thermal_pkg::BIT_ZERO;
                        if (host_nack_ff) begin
                            state_ff <= thermal_pkg::st_idle;
                        end else begin
                            // Host wants more: resend the same register
                            tx_shift_ff <= read_value;
                            sda_oe_ff <= !read_value[7];
                            state_ff <= thermal_pkg::st_rdata;
                        end
                    end
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Command pointer
    // --------------------------------------------------------------
    // Kept across transfers so a plain read reuses the last command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pointer_ff <= thermal_pkg::POINTER_RESET;
        end else if (cmd_take) begin
            pointer_ff <= rx_shift_ff;
        end
    end

    // --------------------------------------------------------------
    // Standby switch
    // --------------------------------------------------------------
    // Only the switch bit is written; the rest of the byte is dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_power_select <= 1'b0;
        end else if (wr_take && pointer_ff == thermal_pkg::REG_SETUP_AND_FLAGS) begin
            low_power_select <= rx_shift_ff[thermal_pkg::LOW_POWER_BIT];
        end
    end

    // --------------------------------------------------------------
    // Conversion capture
    // --------------------------------------------------------------
    temp_capture capture (
        .clock(clock),
        .rst_n(rst_n),
        .sample(sample),
        .low_power(low_power_select),
        .reading_ff(reading),
        .ready_ff(ready)
    );

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign data_ready = ready;

endmodule

// ==== thermal_pkg.sv ====
// Shared constants and types for the thermal sensor register block
package thermal_pkg;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] REG_THERMAL_READING = 8'h00;
    localparam logic [7:0] REG_SETUP_AND_FLAGS = 8'h01;
    localparam logic [7:0] THERMAL_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam int LOW_POWER_BIT = 7;
    localparam int READY_BIT = 6;

    // --------------------------------------------------------------
    // Reading format
    // --------------------------------------------------------------
    localparam int SAMPLE_WIDTH = 12;
    localparam int FRAC_BITS = 2;
    localparam logic [9:0] SAT_HIGH_WIDE = 10'h07F;
    localparam logic [9:0] SAT_LOW_WIDE = 10'h380;
    localparam logic [7:0] SAT_HIGH = 8'h7F;
    localparam logic [7:0] SAT_LOW = 8'h80;

    // --------------------------------------------------------------
    // Serial link
    // --------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam int DIR_BIT = 0;
    localparam logic [6:0] ADDR_DEFAULT = 7'h4D;

    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_addr = 7'h02,
        st_cmd = 7'h04,
        st_wdata = 7'h08,
        st_ack = 7'h10,
        st_rdata = 7'h20,
        st_mack = 7'h40
    } link_state_type;

    // Conversion result from the sensing front end, in quarter degrees
    typedef struct packed {
        logic valid;
        logic [SAMPLE_WIDTH-1:0] quarters;
    } sample_type;

    // Synchronised bus line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_type;

endpackage

// ==== temp_capture.sv ====
// Converts samples to whole degrees and keeps the reading and ready flag
`timescale 1ns/1ps
module temp_capture (
    input wire logic clock,
    input wire logic rst_n,
    input wire thermal_pkg::sample_type sample,
    input wire logic low_power,
    output logic [7:0] reading_ff,
    output logic ready_ff
);

    // --------------------------------------------------------------
    // Floor and saturate
    // --------------------------------------------------------------
    logic [9:0] whole;
    logic [7:0] nxt_reading;

    // Arithmetic shift drops the fraction, which rounds toward minus
    assign whole = sample.quarters[thermal_pkg::SAMPLE_WIDTH-1:thermal_pkg::FRAC_BITS];

    always_comb begin
        if (!whole[9] && (whole > thermal_pkg::SAT_HIGH_WIDE)) begin
            nxt_reading = thermal_pkg::SAT_HIGH;
        end else if (whole[9] && (whole < thermal_pkg::SAT_LOW_WIDE)) begin
            nxt_reading = thermal_pkg::SAT_LOW;
        end else begin
            nxt_reading = whole[7:0];
        end
    end

    // --------------------------------------------------------------
    // Reading register
    // --------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reading_ff <= thermal_pkg::THERMAL_RESET;
        end else if (sample.valid && !low_power) begin
            // Loaded in the same edge that raises the ready flag
            reading_ff <= nxt_reading;
        end
    end

    // --------------------------------------------------------------
    // Data ready flag
    // --------------------------------------------------------------
    // Standby dominates: a sample landing as standby engages is dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= 1'b0;
        end else if (low_power) begin
            ready_ff <= 1'b0;
        end else if (sample.valid) begin
            ready_ff <= 1'b1;
        end
    end

endmodule

// ==== thermal_sensor_regs_assertions.sv ====
// Concurrent checks on the ports of the thermal sensor register block
`timescale 1ns/1ps
module thermal_sensor_regs_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [6:0] dev_addr,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire thermal_pkg::sample_type sample,
    input wire logic low_power_select,
    input wire logic data_ready
);
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence s_taken;
        sample.valid && !low_power_select;
    endsequence
    sequence s_held;
        sda_oe [*6];
    endsequence
    property p_ready_on_sample;
        s_taken |=> data_ready;
    endproperty
    a_ready_on_sample: assert property (p_ready_on_sample)
        else $error("ready flag missed a sample");
    property p_ready_cause;
        $rose(data_ready) |-> $past(sample.valid);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready flag rose without a sample");
    property p_ready_holds;
        data_ready && !low_power_select |=> data_ready;
    endproperty
    a_ready_holds: assert property (p_ready_holds)
        else $error("ready flag dropped outside standby");
    property p_standby_clears;
        low_power_select |=> !data_ready;
    endproperty
    a_standby_clears: assert property (p_standby_clears)
        else $error("ready flag set during standby");
    property p_reset_clear;
        $rose(nrst) |-> !low_power_select && !data_ready;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags not clear after reset");
    property p_oe_when_low;
        $changed(sda_oe) |-> !scl_pin && !$past(scl_pin);
    endproperty
    a_oe_when_low: assert property (p_oe_when_low)
        else $error("data line changed while bus clock high");
    property p_oe_stands;
        $rose(sda_oe) |=> s_held;
    endproperty
    a_oe_stands: assert property (p_oe_stands)
        else $error("data line pull shorter than a bit");
    property p_standby_by_bus;
        $changed(low_power_select) |-> !scl_pin;
    endproperty
    a_standby_by_bus: assert property (p_standby_by_bus)
        else $error("standby switch changed outside a write");
endmodule

bind thermal_sensor_regs thermal_sensor_regs_checker thermal_sensor_regs_checker_inst (
    .clock, .nrst, .dev_addr, .scl_pin, .sda_in, .sda_out, .sda_oe, .sample,
    .low_power_select, .data_ready
);

// ==== host_model.sv ====
// Two-wire bus master model that drives the sensor's serial port
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic sda_wire,
    output logic scl,
    output logic pull_low
);
    // --------------------------------------------------------------
    // Bus phases, eight clocks per bit
    // --------------------------------------------------------------
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic start_cond();
        pull_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    // Releases the data line and waits two clocks before raising the clock
    task automatic restart_cond();
        pull_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        start_cond();
    endtask
    task automatic stop_cond();
        pull_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        pull_low <= 1'b0;
        tick(4);
    endtask
    task automatic bit_step(input logic b, output logic r);
        pull_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda_wire;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    // Sends d most significant bit first, then hb in the ninth slot
    task automatic xbyte(input logic [7:0] d, input logic hb, output logic [7:0] q,
                         output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_step(d[i], q[i]);
        end
        bit_step(hb, r);
        acked = !r;
    endtask
endmodule

// ==== thermal_sensor_regs_test.sv ====
// Self-checking bench for the thermal sensor register block
`timescale 1ns/1ps
module thermal_sensor_regs_test;
    // --------------------------------------------------------------
    // Set-up and helpers
    // --------------------------------------------------------------
    localparam logic [6:0] DEV = 7'h4A;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sda_oe, sda_out, scl, pull_low, sda_wire, low_power_select, data_ready;
    thermal_pkg::sample_type sample = '0;
    int n_fail = 0;
    int cmp_count = 0;
    logic [11:0] qv [11] = '{12'h800, 12'h208, 12'h1FC, 12'h1FA, 12'h065, 12'h001,
                             12'h000, 12'hFFF, 12'hF9B, 12'hF25, 12'hEFC};
    logic [7:0] ev [11] = '{8'h80, 8'h7F, 8'h7F, 8'h7E, 8'h19, 8'h00,
                            8'h00, 8'hFF, 8'hE6, 8'hC9, 8'hBF};
    always #10 clock = ~clock;
    // Open-drain line with pull-up
    assign sda_wire = !pull_low && !(sda_oe && !sda_out);
    thermal_sensor_regs thermal_sensor_regs_inst (
        .clock(clock), .nrst(nrst), .dev_addr(DEV), .scl_pin(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .sample(sample),
        .low_power_select(low_power_select), .data_ready(data_ready)
    );
    host_model host_model_inst (
        .clock(clock), .sda_wire(sda_wire), .scl(scl), .pull_low(pull_low)
    );
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
                             input logic [7:0] exp_acks);
        logic [7:0] q;
        logic a0, a1, a2;
        host_model_inst.start_cond();
        host_model_inst.xbyte({a, 1'b0}, 1'b1, q, a0);
        a1 = 1'b0;
        a2 = 1'b0;
        if (a0) begin
            host_model_inst.xbyte(cmd, 1'b1, q, a1);
            host_model_inst.xbyte(d, 1'b1, q, a2);
        end
        host_model_inst.stop_cond();
        check("acks", {5'h00, a0, a1, a2}, exp_acks);
    endtask
    // Without fresh, the read relies on the pointer left by earlier traffic
    task automatic reg_read(input logic fresh, input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        host_model_inst.start_cond();
        if (fresh) begin
            host_model_inst.xbyte({DEV, 1'b0}, 1'b1, q, a);
            host_model_inst.xbyte(cmd, 1'b1, q, a);
            host_model_inst.restart_cond();
        end
        host_model_inst.xbyte({DEV, 1'b1}, 1'b1, q, a);
        host_model_inst.xbyte(8'hFF, 1'b1, q, a);
        host_model_inst.stop_cond();
        check("read data", q, exp);
    endtask
    task automatic put_sample(input logic [11:0] v);
        sample <= {1'b1, v};
        @(posedge clock);
        sample <= '0;
        @(posedge clock);
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
    initial begin
        logic [7:0] q;
        logic a;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (6) @(posedge clock);
        check("standby", {7'h00, low_power_select}, 8'h00);
        check("ready", {7'h00, data_ready}, 8'h00);
        reg_read(1'b0, 8'h00, thermal_pkg::THERMAL_RESET);
        reg_read(1'b1, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h00);
        reg_read(1'b1, 8'h02, 8'h00);
        for (int i = 0; i < 11; i++) begin
            put_sample(qv[i]);
            reg_read(1'b1, thermal_pkg::REG_THERMAL_READING, ev[i]);
        end
        check("ready", {7'h00, data_ready}, 8'h01);
        reg_read(1'b0, 8'h00, ev[10]);
        reg_read(1'b1, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h40);
        reg_read(1'b0, 8'h00, 8'h40);
        reg_write(DEV, thermal_pkg::REG_THERMAL_READING, 8'h55, 8'h07);
        reg_read(1'b1, thermal_pkg::REG_THERMAL_READING, ev[10]);
        reg_write(DEV, thermal_pkg::REG_SETUP_AND_FLAGS, 8'hFF, 8'h07);
        check("standby", {7'h00, low_power_select}, 8'h01);
        check("ready", {7'h00, data_ready}, 8'h00);
        reg_read(1'b1, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h80);
        put_sample(12'h064);
        check("ready", {7'h00, data_ready}, 8'h00);
        reg_write(DEV, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h00, 8'h07);
        reg_read(1'b1, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h00);
        put_sample(12'h064);
        reg_read(1'b1, thermal_pkg::REG_THERMAL_READING, 8'h19);
        reg_write(DEV ^ 7'h01, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h80, 8'h00);
        check("standby", {7'h00, low_power_select}, 8'h00);
        // Host acknowledges the first byte, so the same register comes again
        host_model_inst.start_cond();
        host_model_inst.xbyte({DEV, 1'b1}, 1'b1, q, a);
        host_model_inst.xbyte(8'hFF, 1'b0, q, a);
        check("first of two", q, 8'h19);
        host_model_inst.xbyte(8'hFF, 1'b1, q, a);
        host_model_inst.stop_cond();
        check("second of two", q, 8'h19);
        // Reset in mid-run with standby on and the pointer on setup
        reg_write(DEV, thermal_pkg::REG_SETUP_AND_FLAGS, 8'h80, 8'h07);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (6) @(posedge clock);
        check("standby", {7'h00, low_power_select}, 8'h00);
        check("ready", {7'h00, data_ready}, 8'h00);
        reg_read(1'b0, 8'h00, thermal_pkg::THERMAL_RESET);
        give_verdict();
    end
endmodule
